//--- src/arp_pkg.sv
package arp_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CFG = 32'hFFFF0518;
  localparam logic [31:0] ADDR_RC_LIMIT = 32'hFFFF0534;
  localparam logic [31:0] ADDR_RC_VALUE = 32'hFFFF0538;
  localparam logic [31:0] ADDR_THRESH = 32'hFFFF053C;
  localparam logic [31:0] ADDR_TH_LIMIT = 32'hFFFF0540;
  localparam logic [31:0] ADDR_TH_VALUE = 32'hFFFF0544;
  localparam logic [31:0] ADDR_ACCUM = 32'hFFFF0548;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFF054C;
  // Configuration field positions
  localparam int CFG_GROUND_CONN = 7;
  localparam int CFG_ACC_HI = 6;
  localparam int CFG_ACC_LO = 5;
  localparam int CFG_CMP_HI = 4;
  localparam int CFG_CMP_LO = 3;
  localparam int CFG_OVR_EN = 2;
  localparam int CFG_GND_RES = 1;
  localparam int CFG_RC_EN = 0;
  // Status bit positions
  localparam int STS_READY = 0;
  localparam int STS_THRESH = 1;
  localparam int STS_OVR = 2;
  localparam int STS_ACC = 3;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] RC_LIMIT_RST = 16'h0001;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0] TH_LIMIT_RST = 8'h01;
  // Mode encodings of both two-bit fields
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  // Overrange persistence time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int OVR_TIME_NS = 125000;
  localparam int OVR_CYCLES =
    (OVR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : arp_pkg

//--- src/arp_postproc.sv
// Operation
// R1: One 8-bit read/write extended config register, zero after reset.
// R2: Bit 7 connects switched ground pin to analog ground; clear opens it.
// R3: Bit 1 set inserts series resistor in ground switch path; clear bypasses.
// R4: Accumulator mode 00 disables and clears; software waits two results.
// R5: Mode 01 adds signed results to accumulator, clamped at zero minimum.
// R6: Mode 10 accumulates like 01 but total may go below zero.
// R7: Mode 11 adds accumulator comparator; interrupts only when masked in.
// R8: Bits 4:3 compare: 00 off, 01 irq when magnitude reaches threshold.
// R9: Compare mode 10 counts hits, interrupts at limit; a miss resets count.
// R10: Compare mode 11 like 10, but a miss decrements count toward zero.
// R11: Bit 2 enables overrange check; flag after over 125 us out of range.
// R12: Software leaves overrange check off in converter low power mode.
// R13: Bit 0 set interrupts only when result count equals result count limit.
// R14: Bit 0 clear interrupts after every completed conversion.
// R15: Result count wraps to zero at limit and on control or mode writes.
// R16: Unipolar compares threshold bits 15:0, two's complement only bits 14:0.
// R17: Accumulator and counters update once per conversion, with ready.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module arp_postproc
  import arp_pkg::*;
#(
  parameter int OVR_LIMIT = OVR_CYCLES,
  parameter int RES_W = 24
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Primary converter side
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic bipolar,
  input wire logic overrange_raw,
  input wire logic ctrl_written,
  input wire logic acc_irq_mask,
  // Outputs
  output logic conv_irq,
  output logic ground_switch_connect,
  output logic ground_series_resistor_enable
);

  localparam int OW = $clog2(OVR_LIMIT + 2);
  localparam logic [OW-1:0] OVR_LIM = OW'(OVR_LIMIT);

  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] rc_limit;
    logic [15:0] rc_value;
    logic [15:0] thresh;
    logic [7:0] th_limit;
    logic [7:0] th_value;
    logic [31:0] acc;
    logic [OW-1:0] ovr_cnt;
    logic [3:0] sts;
    logic irq;
    logic [31:0] rdata;
    logic gsw;
    logic gres;
  } arp_state_t;

  arp_state_t q;
  arp_state_t d;

  // All checks below run on the system clock, quiet during reset
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic [1:0] acc_mode;
  logic [1:0] cmp_mode;
  logic [31:0] sres;
  logic [RES_W-1:0] absr;
  logic ge;
  logic [31:0] sum;
  logic [15:0] rc_inc;
  logic [7:0] th_inc;
  logic cmp_evt;
  logic acc_evt;
  logic rc_evt;
  logic ovr_on;

  assign acc_mode = q.cfg[CFG_ACC_HI:CFG_ACC_LO];
  assign cmp_mode = q.cfg[CFG_CMP_HI:CFG_CMP_LO];

  // Signed result and its magnitude; unipolar results are always positive
  assign sres = bipolar ? {{(32-RES_W){conv_result[RES_W-1]}}, conv_result}
                        : {{(32-RES_W){1'b0}}, conv_result};
  assign absr = (bipolar && conv_result[RES_W-1]) ? -conv_result
                                                  : conv_result;

  // R16: threshold width
  // Full-scale negative magnitude lands in the top bit and always counts
  assign ge = bipolar
    ? (absr[RES_W-1] || absr[RES_W-2 -: 15] >= q.thresh[14:0])
    : (absr[RES_W-1 -: 16] >= q.thresh);

  assign sum = q.acc + sres;
  assign rc_inc = q.rc_value + 16'h0001;
  assign th_inc = q.th_value + 8'h01;
  assign ovr_on = q.cfg[CFG_OVR_EN] && overrange_raw;

  // Next state of the whole block
  always_comb
  begin
    d = q;
    d.irq = 1'b0;
    d.rdata = 32'h0000_0000;
    cmp_evt = 1'b0;
    acc_evt = 1'b0;
    rc_evt = 1'b0;
    // R1: register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CFG: d.cfg = reg_wdata[7:0];
        ADDR_RC_LIMIT: d.rc_limit = reg_wdata[15:0];
        ADDR_THRESH: d.thresh = reg_wdata[15:0];
        ADDR_TH_LIMIT: d.th_limit = reg_wdata[7:0];
        default: ;
      endcase
    end
    // R17: one update per conversion
    if (conv_done)
    begin
      d.sts[STS_READY] = 1'b1;
      // R5: clamped accumulate
      // R6: unclamped accumulate
      case (acc_mode)
        MODE_2: d.acc = sum;
        MODE_1, MODE_3: d.acc = sum[31] ? 32'h0000_0000 : sum;
        default: ;
      endcase
      // R7: accumulator comparator against the threshold
      if (acc_mode == MODE_3 && !d.acc[31] && d.acc >= {16'h0000, q.thresh})
        acc_evt = 1'b1;
      // R8: level compare
      // R9: count with reset on miss
      // R10: count with decrement on miss
      case (cmp_mode)
        MODE_1: cmp_evt = ge;
        MODE_2, MODE_3:
        begin
          if (ge)
          begin
            if (th_inc >= q.th_limit)
            begin
              cmp_evt = 1'b1;
              d.th_value = 8'h00;
            end
            else
              d.th_value = th_inc;
          end
          else if (cmp_mode == MODE_2 || q.th_value == 8'h00)
            d.th_value = 8'h00;
          else
            d.th_value = q.th_value - 8'h01;
        end
        default: ;
      endcase
      // R13: interrupt divider
      // R14: every conversion when off
      // R15: wrap at limit
      if (q.cfg[CFG_RC_EN])
      begin
        if (rc_inc == q.rc_limit)
        begin
          rc_evt = 1'b1;
          d.rc_value = 16'h0000;
        end
        else
          d.rc_value = rc_inc;
      end
      else
        rc_evt = 1'b1;
    end
    // R4: mode 00 holds accumulator at zero
    if (acc_mode == MODE_OFF)
      d.acc = 32'h0000_0000;
    if (cmp_mode == MODE_OFF)
      d.th_value = 8'h00;
    // R15: reconfiguring the converter restarts the count
    if (ctrl_written)
      d.rc_value = 16'h0000;
    // R11: persistence counter; flag only after the limit is exceeded
    if (!ovr_on)
      d.ovr_cnt = '0;
    else if (q.ovr_cnt != OVR_LIM)
      d.ovr_cnt = q.ovr_cnt + OW'(1);
    // Status read returns and clears; a new event in that cycle still sets
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CFG: d.rdata = {24'h000000, q.cfg};
        ADDR_RC_LIMIT: d.rdata = {16'h0000, q.rc_limit};
        ADDR_RC_VALUE: d.rdata = {16'h0000, q.rc_value};
        ADDR_THRESH: d.rdata = {16'h0000, q.thresh};
        ADDR_TH_LIMIT: d.rdata = {24'h000000, q.th_limit};
        ADDR_TH_VALUE: d.rdata = {24'h000000, q.th_value};
        ADDR_ACCUM: d.rdata = q.acc;
        ADDR_STATUS:
        begin
          d.rdata = {28'h0000000, q.sts};
          d.sts = {3'h0, d.sts[STS_READY] & conv_done};
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (cmp_evt)
      d.sts[STS_THRESH] = 1'b1;
    if (acc_evt)
      d.sts[STS_ACC] = 1'b1;
    if (ovr_on && q.ovr_cnt == OVR_LIM)
      d.sts[STS_OVR] = 1'b1;
    // R7: accumulator interrupt only when masked in
    d.irq = rc_evt || cmp_evt || (acc_evt && acc_irq_mask);
    // R2: ground switch
    // R3: series resistor only while the switch is closed
    d.gsw = d.cfg[CFG_GROUND_CONN];
    d.gres = d.cfg[CFG_GROUND_CONN] & d.cfg[CFG_GND_RES];
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.rc_limit <= RC_LIMIT_RST;
      q.thresh <= THRESH_RST;
      q.th_limit <= TH_LIMIT_RST;
    end
    else
      q <= d;
  end

  assign reg_rdata = q.rdata;
  assign conv_irq = q.irq;
  assign ground_switch_connect = q.gsw;
  assign ground_series_resistor_enable = q.gres;

  // R2: switch follows written bit
  a_gnd_switch_write: assert property ( // R2
    reg_wr && reg_addr == ADDR_CFG |=>
      ground_switch_connect == $past(reg_wdata[CFG_GROUND_CONN]))
    else $error("ground switch does not follow bit 7");
  // R3: resistor never without switch
  a_res_with_switch: assert property ( // R3
    ground_series_resistor_enable |-> ground_switch_connect)
    else $error("series resistor enabled with switch open");
  // R4: accumulator cleared
  a_acc_off_clear: assert property ( // R4
    acc_mode == MODE_OFF |=> q.acc == 32'h0000_0000)
    else $error("accumulator not cleared in mode 00");
  // R5: clamp at zero
  a_acc_clamp_zero: assert property ( // R5
    acc_mode == MODE_1 && conv_done |=> !q.acc[31])
    else $error("accumulator below zero in mode 01");
  // R6: plain signed sum
  a_acc_free_sum: assert property ( // R6
    acc_mode == MODE_2 && conv_done |=> q.acc == $past(q.acc) + $past(sres))
    else $error("accumulator sum wrong in mode 10");
  // R7: masked accumulator compare
  a_acc_irq_masked: assert property ( // R7
    acc_evt && !acc_irq_mask && !rc_evt && !cmp_evt |=> !conv_irq)
    else $error("accumulator interrupt not masked");
  // R8: level compare interrupt
  a_cmp_level_irq: assert property ( // R8
    cmp_mode == MODE_1 && conv_done && ge |=> conv_irq)
    else $error("no interrupt on threshold hit");
  // R9: miss resets count
  a_cmp_miss_reset: assert property ( // R9
    cmp_mode == MODE_2 && conv_done && !ge |=> q.th_value == 8'h00)
    else $error("threshold count not reset on miss");
  // R10: miss decrements count
  a_cmp_miss_dec: assert property ( // R10
    cmp_mode == MODE_3 && conv_done && !ge && q.th_value != 8'h00 |=>
      q.th_value == $past(q.th_value) - 8'h01)
    else $error("threshold count not decremented");
  // R11: flag only after persistence
  a_ovr_persist: assert property ( // R11
    !q.sts[STS_OVR] && q.ovr_cnt != OVR_LIM |=> !q.sts[STS_OVR])
    else $error("overrange flag set too early");
  // R14: interrupt every conversion
  a_rc_every_conv: assert property ( // R14
    !q.cfg[CFG_RC_EN] && conv_done |=> conv_irq)
    else $error("missing per-conversion interrupt");
  // R13: interrupt and wrap at limit
  a_rc_limit_wrap: assert property ( // R13
    q.cfg[CFG_RC_EN] && conv_done && rc_inc == q.rc_limit && !ctrl_written
      |=> conv_irq && q.rc_value == 16'h0000)
    else $error("result count did not wrap with interrupt");
  // R15: control write clears count
  a_rc_ctrl_clear: assert property ( // R15
    ctrl_written |=> q.rc_value == 16'h0000)
    else $error("result count not cleared on control write");

endmodule : arp_postproc

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  import arp_pkg::*;
  // Short overrange window keeps the run brief
  localparam int OVR_SIM = 8;
  logic sys_clk, rst_n, reg_wr, reg_rd, conv_done, bipolar, overrange_raw;
  logic ctrl_written, acc_irq_mask, conv_irq, gnd_on, gnd_res, irq;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, acc, d;
  logic [23:0] x;
  logic [23:0] conv_result;
  logic [15:0] th;
  int num_errors, samples_checked, cycles, cnt;

  arp_postproc #(.OVR_LIMIT(OVR_SIM), .RES_W(24)) arp_postproc_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_result(conv_result), .bipolar(bipolar),
    .overrange_raw(overrange_raw), .ctrl_written(ctrl_written),
    .acc_irq_mask(acc_irq_mask), .conv_irq(conv_irq),
    .ground_switch_connect(gnd_on),
    .ground_series_resistor_enable(gnd_res));

  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the roughly 430 cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk_word(v, exp);
  endtask : rdc

  // The interrupt pulse is only one cycle wide, so sample it here
  task automatic conv(input logic [23:0] r, output logic q);
    @(posedge sys_clk);
    conv_result <= r;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    #1;
    q = conv_irq;
  endtask : conv

  function automatic logic hit(input logic [23:0] v, input logic [15:0] t,
                               input logic bip);
    logic [23:0] m;
    m = v[23] ? -v : v;
    if (!bip)
      return v[23:8] >= t;
    return v == 24'h800000 || m[22:8] >= t[14:0];
  endfunction : hit

  function automatic logic [31:0] acc_model(input logic [31:0] a,
                                            input logic [23:0] v,
                                            input logic clamp);
    logic signed [31:0] s;
    s = $signed(a) + $signed({{8{v[23]}}, v});
    if (clamp && s < 0)
      s = 32'h0;
    return s;
  endfunction : acc_model

  // Main sequence
  initial
  begin
    {rst_n, reg_wr, reg_rd, conv_done, bipolar, overrange_raw} = 6'h00;
    {ctrl_written, acc_irq_mask, reg_addr, reg_wdata} = 66'h0;
    conv_result = 24'h0;
    void'($urandom(46829));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and a hole in the map
    rdc(ADDR_CFG, 32'h0);
    rdc(ADDR_RC_LIMIT, 32'h1);
    rdc(32'hFFFF0600, 32'h0);
    // read back and ground switch pins
    for (int k = 0; k < 4; k++)
    begin
      d = {24'h0, k[1], 5'($urandom), k[0], 1'($urandom)};
      wr(ADDR_CFG, d);
      rdc(ADDR_CFG, d);
      chk_bit(gnd_on, d[7]);
      chk_bit(gnd_res, d[7] & d[1]);
    end
    wr(ADDR_CFG, 32'h0);
    repeat (3)
    begin
      conv(24'($urandom), irq);
      chk_bit(irq, 1'b1);
    end
    rdc(ADDR_STATUS, 32'h1);
    // divided interrupt rate and count reset
    wr(ADDR_RC_LIMIT, 32'h3);
    wr(ADDR_CFG, 32'h01);
    for (int k = 0; k < 7; k++)
    begin
      conv(24'($urandom), irq);
      chk_bit(irq, k % 3 == 2);
    end
    rdc(ADDR_RC_VALUE, 32'h1);
    @(posedge sys_clk);
    ctrl_written <= 1'b1;
    @(posedge sys_clk);
    ctrl_written <= 1'b0;
    rdc(ADDR_RC_VALUE, 32'h0);
    // Limit 0 fires only after 65536 results, so only the comparators can interrupt
    wr(ADDR_RC_LIMIT, 32'h0);
    bipolar <= 1'b1;
    // clear, then clamped and unclamped sums
    for (int m = 1; m <= 3; m++)
    begin
      wr(ADDR_CFG, 32'h01);
      conv(24'h0, irq);
      conv(24'h0, irq);
      rdc(ADDR_ACCUM, 32'h0);
      wr(ADDR_THRESH, 32'h300);
      wr(ADDR_CFG, {25'h0, m[1:0], 5'h01});
      acc = 32'h0;
      for (int k = 0; k < 8; k++)
      begin
        x = (m == 3) ? 24'h200 : (k == 0) ? 24'h800000 : 24'($urandom);
        acc = acc_model(acc, x, m != 2);
        acc_irq_mask <= k[0];
        conv(x, irq);
        // accumulator compare only through the mask
        if (m == 3) chk_bit(irq, k[0] && acc >= 32'h300);
        rdc(ADDR_ACCUM, acc);
      end
    end
    rdc(ADDR_STATUS, 32'h9);
    // count modes, decrement first from a zero count
    bipolar <= 1'b0;
    wr(ADDR_THRESH, 32'h4000);
    wr(ADDR_TH_LIMIT, 32'h3);
    rdc(ADDR_TH_LIMIT, 32'h3);
    cnt = 0;
    for (int m = 3; m >= 2; m--)
    begin
      wr(ADDR_CFG, {27'h0, m[1:0], 3'h1});
      repeat (12)
      begin
        x = 24'($urandom);
        if (hit(x, 16'h4000, 1'b0)) cnt++;
        else cnt = (m == 3 && cnt > 0) ? cnt - 1 : 0;
        conv(x, irq);
        chk_bit(irq, cnt >= 3);
        if (cnt >= 3) cnt = 0;
        rdc(ADDR_TH_VALUE, 32'(cnt));
      end
    end
    // plain compare, both codings, equality corner
    wr(ADDR_CFG, 32'h09);
    repeat (16)
    begin
      th = 16'($urandom);
      x = 24'($urandom);
      if (x[1]) x[23:8] = th;
      bipolar <= x[0];
      wr(ADDR_THRESH, {16'h0, th});
      conv(x, irq);
      chk_bit(irq, hit(x, th, x[0]));
    end
    // normal power only; this bench has no low power mode
    // flag needs more than the window of high cycles
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CFG, {29'h0, k[1], 2'h0});
      rd(ADDR_STATUS, d);
      @(posedge sys_clk);
      overrange_raw <= 1'b1;
      repeat (OVR_SIM + k[0]) @(posedge sys_clk);
      overrange_raw <= 1'b0;
      rdc(ADDR_STATUS, {29'h0, k == 3, 2'h0});
    end
    final_report();
  end
endmodule : tb
